// *** rtl/ets_sequencer.sv ***
`timescale 1ns/1ps
`include "ets_defs.svh"
// Contract
// - Flush held atoms before exception packets
// - Waypoint atom may merge with held atoms
// - Reset traced as reset exception branch
// - Reset never emits waypoint update
// - Last traced waypoint counts as last executed
// - Undefined instruction: update, then exception branch
// - Condition-failed undefined instruction not promoted
// - Passing supervisor/monitor call: update, exception branch
// - Failing supervisor/monitor call not promoted
// - Prefetch abort after waypoint: waypoint, exception
// - Prefetch abort after non-waypoint: update first
// - Data abort after waypoint: waypoint, exception
// - Nonmaskable fast interrupt traced as fast interrupt
// - Data abort after non-waypoint: update first
// - Trace turn-on emits sync at last target
module ets_sequencer #(
   parameter int unsigned ATOM_LIMIT = `ETS_ATOM_MAX  // Atoms before flush
) (
   input  wire logic             clk,       // 10 MHz clock
   input  wire logic             rst,       // Async reset, active high
   input  wire logic             trace_en,  // Tracing switched on
   input  ets_pkg::ets_commit_s  cmt,       // Committed instruction
   input  ets_pkg::ets_exc_s     exc,       // Exception report
   output wire logic             in_ready,  // Core reports accepted
   output wire logic             pkt_valid, // Packet on output
   input  wire logic             pkt_ready, // Output stream accepts
   output ets_pkg::ets_pkt_s     pkt        // Packet contents
);

   // Sizes; the limit is cut to the count width on purpose
   localparam int AW = `ETS_ADDR_W;
   localparam int CW = `ETS_ATOM_CW;
   localparam int BW = `ETS_ATOM_MAX;
   localparam logic [CW-1:0] LIMIT = CW'(ATOM_LIMIT);

   // Tracking state
   logic [CW-1:0]        acc_cnt_r;
   logic [BW-1:0]        acc_bits_r;
   logic                 nonwp_r;
   logic [AW-1:0]        last_exec_r;
   logic [AW-1:0]        last_tgt_r;
   logic                 en_d_r;

   // Pending packets, drained in stream order
   logic                 p_atom_r;
   logic [CW-1:0]        p_atom_cnt_r;
   logic [BW-1:0]        p_atom_bits_r;
   logic                 p_br_r;
   logic [AW-1:0]        p_br_addr_r;
   logic                 p_wpu_r;
   logic [AW-1:0]        p_wpu_addr_r;
   logic                 p_exc_r;
   logic [3:0]           p_exc_code_r;
   logic [AW-1:0]        p_exc_vec_r;
   logic                 p_sync_r;
   logic [AW-1:0]        p_sync_addr_r;

   // Output slot
   logic                 pkt_valid_r;
   ets_pkg::ets_pkt_s    pkt_r;
   ets_pkg::ets_pkt_s    pkt_nxt;

   // Acceptance: nothing new is taken while packets still wait
   // so one exception's packets leave together, and a turn-on
   // cycle takes nothing so the sync cannot slip behind a report
   wire busy     = p_atom_r | p_br_r | p_wpu_r | p_exc_r | p_sync_r;
   wire en_rise  = trace_en & ~en_d_r;
   assign in_ready = ~busy & ~en_rise;
   wire cmt_go   = in_ready & cmt.valid;
   wire exc_go   = in_ready & exc.valid;

   // Waypoint of this commit: indirect taken goes as branch address
   // since its target already tells which way it went
   wire cmt_wp   = cmt_go & cmt.waypoint;
   wire br_go    = cmt_wp & cmt.indirect & cmt.taken & trace_en;
   wire atom_add = cmt_wp & ~(cmt.indirect & cmt.taken) & trace_en;

   // Accumulator after this commit; the waypoint atom joins the
   // held atoms so one atom header carries both
   wire [CW-1:0] acc_cnt_c  = atom_add ? CW'(acc_cnt_r + 1'b1)
                                       : acc_cnt_r;
   wire [BW-1:0] taken_bit  = BW'(cmt.taken) << acc_cnt_r;
   wire [BW-1:0] acc_bits_c = atom_add ? (acc_bits_r | taken_bit)
                                       : acc_bits_r;

   // Tracking state after this commit
   // An update names the latest non-waypoint, so keep its address
   wire          nonwp_c     = cmt_wp ? 1'b0
                             : (cmt_go ? 1'b1 : nonwp_r);
   wire [AW-1:0] last_exec_c = (cmt_go & ~cmt.waypoint) ? cmt.addr
                                                        : last_exec_r;
   wire [AW-1:0] last_tgt_c  = cmt_wp ? cmt.target : last_tgt_r;

   // Exception kind decode
   // Codes outside the list decode to nothing and raise no packets
   wire k_reset = exc.kind == ets_pkg::ETS_EK_RESET;
   wire k_undef = exc.kind == ets_pkg::ETS_EK_UNDEF;
   wire k_supv  = exc.kind == ets_pkg::ETS_EK_SUPV;
   wire k_smon  = exc.kind == ets_pkg::ETS_EK_SMON;
   wire k_pabt  = exc.kind == ets_pkg::ETS_EK_PABT;
   wire k_dabt  = exc.kind == ets_pkg::ETS_EK_DABT;
   wire k_fast  = (exc.kind == ets_pkg::ETS_EK_FAST) |
                  (exc.kind == ets_pkg::ETS_EK_NONMASKABLE_FAST_INTERRUPT);
   wire k_instr = k_undef | k_supv | k_smon;
   wire k_legal = k_reset | k_instr | k_pabt | k_dabt | k_fast;

   // Exception code, nonmaskable shares the fast interrupt code
   // Code values are this block's own choice, held in the defs header
   wire [3:0] exc_code_c =
        k_reset ? `ETS_EXC_RESET
      : k_undef ? `ETS_EXC_UNDEF
      : k_supv  ? `ETS_EXC_SVC
      : k_smon  ? `ETS_EXC_SMC
      : k_pabt  ? `ETS_EXC_PABT
      : k_dabt  ? `ETS_EXC_DABT
      : k_fast  ? `ETS_EXC_FAST
      :           `ETS_EXC_NONE;

   // A condition-failed instruction raises nothing and stays plain
   wire exc_fail = exc_go & k_instr &
                   ~exc.cond_pass;
   wire exc_real = exc_go & k_legal & ~(k_instr & ~exc.cond_pass);

   // Waypoint update: the faulting instruction itself for undefined
   // and calls, the last executed one for aborts and interrupts if
   // any ran since the last waypoint, and never for reset
   wire wpu_need = exc_real &
                   ~k_reset &
                   (k_instr |
                    nonwp_c);
   wire [AW-1:0] wpu_addr_c = k_instr ? exc.fault_addr
                                      : last_exec_c;

   // Atom flush ahead of a branch, an exception or a full header
   // so held atoms always leave ahead of an update or a branch
   wire flush = trace_en & (acc_cnt_c != '0) &
                (exc_real | br_go | (acc_cnt_c == LIMIT));

   // Output selection in stream order: atoms, branch, update, exception
   // A fixed priority suffices: at most one report is ever in flight,
   // since the core is held off until every entry has drained
   wire slot_free = ~pkt_valid_r | pkt_ready;
   wire sel_atom  = slot_free & p_atom_r;
   wire sel_br    = slot_free & ~p_atom_r & p_br_r;
   wire sel_wpu   = slot_free & ~p_atom_r & ~p_br_r & p_wpu_r;
   wire sel_exc   = slot_free & ~p_atom_r & ~p_br_r & ~p_wpu_r
                  & p_exc_r;
   wire sel_sync  = slot_free & ~p_atom_r & ~p_br_r & ~p_wpu_r
                  & ~p_exc_r & p_sync_r;
   wire sel_any   = sel_atom | sel_br | sel_wpu | sel_exc | sel_sync;

   // Next packet from the selected pending entry
   // Fields a packet does not use go out as zero
   wire ets_pkg::ets_pkt_kind_e kind_nxt =
        sel_atom ? ets_pkg::ETS_PK_ATOM
      : sel_br   ? ets_pkg::ETS_PK_BRA
      : sel_wpu  ? ets_pkg::ETS_PK_WPU
      : sel_exc  ? ets_pkg::ETS_PK_EXCB
      :            ets_pkg::ETS_PK_ISYNC;
   wire [AW-1:0] addr_nxt =
        sel_br   ? p_br_addr_r
      : sel_wpu  ? p_wpu_addr_r
      : sel_exc  ? p_exc_vec_r
      : sel_sync ? p_sync_addr_r
      :            '0;
   assign pkt_nxt = '{kind:      kind_nxt,
                      addr:      addr_nxt,
                      exc_code:  sel_exc ? p_exc_code_r : `ETS_EXC_NONE,
                      atom_cnt:  sel_atom ? p_atom_cnt_r : '0,
                      atom_bits: sel_atom ? p_atom_bits_r : '0};

   assign pkt_valid = pkt_valid_r;
   assign pkt       = pkt_r;

   // Atom accumulator, cleared by a flush or while tracing is off
   // Atoms held over a trace-off would speak of code never traced
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_cnt_r  <= '0;
         acc_bits_r <= '0;
      end else if (flush || !trace_en) begin
         acc_cnt_r  <= '0;
         acc_bits_r <= '0;
      end else begin
         acc_cnt_r  <= acc_cnt_c;
         acc_bits_r <= acc_bits_c;
      end
   end

   // Program position tracking, kept even while tracing is off
   // Any taken exception acts as a waypoint at its vector; a failed
   // call is just a plain executed instruction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nonwp_r     <= 1'b0;
         last_exec_r <= '0;
         last_tgt_r  <= '0;
         en_d_r      <= 1'b0;
      end else begin
         en_d_r      <= trace_en;
         nonwp_r     <= exc_real ? 1'b0
                      : (exc_fail ? 1'b1 : nonwp_c);
         last_exec_r <= exc_fail ? exc.fault_addr : last_exec_c;
         last_tgt_r  <= exc_real ? exc.vector : last_tgt_c;
      end
   end

   // Pending atom header
   // Set only while nothing waits, so a set never meets a clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p_atom_r      <= 1'b0;
         p_atom_cnt_r  <= '0;
         p_atom_bits_r <= '0;
      end else if (flush) begin
         p_atom_r      <= 1'b1;
         p_atom_cnt_r  <= acc_cnt_c;
         p_atom_bits_r <= acc_bits_c;
      end else if (sel_atom) begin
         p_atom_r      <= 1'b0;
      end
   end

   // Pending branch address of an indirect waypoint
   // It leaves ahead of an exception raised in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p_br_r      <= 1'b0;
         p_br_addr_r <= '0;
      end else if (br_go) begin
         p_br_r      <= 1'b1;
         p_br_addr_r <= cmt.target;
      end else if (sel_br) begin
         p_br_r      <= 1'b0;
      end
   end

   // Pending waypoint update
   // Address fixed when the report is taken; later commits wait
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p_wpu_r      <= 1'b0;
         p_wpu_addr_r <= '0;
      end else if (wpu_need && trace_en) begin
         p_wpu_r      <= 1'b1;
         p_wpu_addr_r <= wpu_addr_c;
      end else if (sel_wpu) begin
         p_wpu_r      <= 1'b0;
      end
   end

   // Pending exception branch address
   // Its vector also becomes the last target for a later sync
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p_exc_r      <= 1'b0;
         p_exc_code_r <= `ETS_EXC_NONE;
         p_exc_vec_r  <= '0;
      end else if (exc_real && trace_en) begin
         p_exc_r      <= 1'b1;
         p_exc_code_r <= exc_code_c;
         p_exc_vec_r  <= exc.vector;
      end else if (sel_exc) begin
         p_exc_r      <= 1'b0;
      end
   end

   // Pending sync on turn-on, at the last waypoint target
   // A rise while a sync still waits re-arms it: the set wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p_sync_r      <= 1'b0;
         p_sync_addr_r <= '0;
      end else if (en_rise) begin
         p_sync_r      <= 1'b1;
         p_sync_addr_r <= last_tgt_r;
      end else if (sel_sync) begin
         p_sync_r      <= 1'b0;
      end
   end

   // Output slot
   // A packet stands until taken, so the sink sees each once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pkt_valid_r <= 1'b0;
         pkt_r       <= '0;
      end else if (sel_any) begin
         pkt_valid_r <= 1'b1;
         pkt_r       <= pkt_nxt;
      end else if (pkt_ready) begin
         pkt_valid_r <= 1'b0;
      end
   end

endmodule : ets_sequencer

// *** rtl/ets_defs.svh ***
`ifndef ETS_DEFS_SVH
`define ETS_DEFS_SVH

// Address width of commit, vector and packet addresses
`define ETS_ADDR_W     32
// Atom accumulator depth and the width of its count
`define ETS_ATOM_MAX   5
`define ETS_ATOM_CW    3

// Exception codes carried by an exception branch address packet
`define ETS_EXC_NONE   4'h0
`define ETS_EXC_RESET  4'h1
`define ETS_EXC_UNDEF  4'h2
`define ETS_EXC_SVC    4'h3
`define ETS_EXC_SMC    4'h4
`define ETS_EXC_PABT   4'h5
`define ETS_EXC_DABT   4'h6
`define ETS_EXC_FAST   4'h7

`endif

// *** rtl/ets_pkg.sv ***
`include "ets_defs.svh"

package ets_pkg;

   // Exception kinds reported by the core
   typedef enum logic [3:0] {
      ETS_EK_RESET = 4'b0000,
      ETS_EK_UNDEF = 4'b0001,
      ETS_EK_SUPV  = 4'b0010,
      ETS_EK_SMON  = 4'b0011,
      ETS_EK_PABT  = 4'b0100,
      ETS_EK_DABT  = 4'b0101,
      ETS_EK_FAST  = 4'b0110,
      ETS_EK_NONMASKABLE_FAST_INTERRUPT  = 4'b0111
   } ets_exc_kind_e;

   // Packet kinds leaving the sequencer
   typedef enum logic [2:0] {
      ETS_PK_ISYNC = 3'b000,
      ETS_PK_ATOM  = 3'b001,
      ETS_PK_WPU   = 3'b010,
      ETS_PK_BRA   = 3'b011,
      ETS_PK_EXCB  = 3'b100
   } ets_pkt_kind_e;

   // One committed instruction
   typedef struct packed {
      logic                     valid;
      logic [`ETS_ADDR_W-1:0]   addr;
      logic                     waypoint;
      logic                     indirect;
      logic                     taken;
      logic [`ETS_ADDR_W-1:0]   target;
   } ets_commit_s;

   // One exception
   typedef struct packed {
      logic                     valid;
      ets_exc_kind_e            kind;
      logic                     cond_pass;
      logic [`ETS_ADDR_W-1:0]   fault_addr;
      logic [`ETS_ADDR_W-1:0]   vector;
   } ets_exc_s;

   // One trace packet
   typedef struct packed {
      ets_pkt_kind_e            kind;
      logic [`ETS_ADDR_W-1:0]   addr;
      logic [3:0]               exc_code;
      logic [`ETS_ATOM_CW-1:0]  atom_cnt;
      logic [`ETS_ATOM_MAX-1:0] atom_bits;
   } ets_pkt_s;

endpackage : ets_pkg

// *** tb/ets_sequencer_properties.sv ***
`timescale 1ns/1ps
`include "ets_defs.svh"
module ets_sequencer_properties (
   input wire logic            clk,       // Clock
   input wire logic            rst,       // Reset
   input wire logic            trace_en,  // Tracing on
   input ets_pkg::ets_commit_s cmt,       // Commit
   input ets_pkg::ets_exc_s    exc,       // Exception
   input wire logic            in_ready,  // Report accepted
   input wire logic            pkt_valid, // Packet valid
   input wire logic            pkt_ready, // Sink ready
   input ets_pkg::ets_pkt_s    pkt        // Packet
);
   localparam logic [3:0] CODE [8] = '{`ETS_EXC_RESET, `ETS_EXC_UNDEF,
      `ETS_EXC_SVC, `ETS_EXC_SMC, `ETS_EXC_PABT, `ETS_EXC_DABT,
      `ETS_EXC_FAST, `ETS_EXC_FAST};
   logic        pend_r;
   logic [2:0]  idx_r;
   logic [31:0] fa_r;
   logic [31:0] vec_r;
   logic [31:0] tgt_r;
   // Accepted exception and whether it makes packets
   wire logic ex_take = exc.valid && in_ready;
   wire logic call_k = exc.kind inside {ets_pkg::ETS_EK_UNDEF,
      ets_pkg::ETS_EK_SUPV, ets_pkg::ETS_EK_SMON};
   wire logic ex_live = ex_take && !exc.kind[3] && (exc.cond_pass || !call_k);
   wire logic o_excb = pkt_valid && pkt.kind == ets_pkg::ETS_PK_EXCB;
   wire logic o_wpu = pkt_valid && pkt.kind == ets_pkg::ETS_PK_WPU;
   // Remember the exception whose packets are in flight
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_r <= 1'b0;
         idx_r <= 3'h0;
         fa_r <= 32'h0;
         vec_r <= 32'h0;
      end else if (ex_take) begin
         pend_r <= ex_live && trace_en && !pkt_valid;
         idx_r <= exc.kind[2:0];
         fa_r <= exc.fault_addr;
         vec_r <= exc.vector;
      end else if (o_excb && pkt_ready) begin
         pend_r <= 1'b0;
      end
   end
   // Target of the most recent waypoint
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         tgt_r <= 32'h0;
      else if (ex_live)
         tgt_r <= exc.vector;
      else if (cmt.valid && in_ready && cmt.waypoint)
         tgt_r <= cmt.target;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wpu_out;
      o_wpu && pkt_ready;
   endsequence
   sequence s_excb_next;
      o_excb;
   endsequence
   a_stall_hold: assert property (
      pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt))
      else $error("packet changed while stalled");
   a_wpu_then_excb: assert property (s_wpu_out |=> s_excb_next)
      else $error("update not followed by exception branch");
   a_reset_no_wpu: assert property (
      pend_r && idx_r == 3'h0 |-> !o_wpu)
      else $error("update emitted for reset");
   a_excb_code: assert property (
      pend_r && o_excb |-> pkt.exc_code == CODE[idx_r])
      else $error("wrong exception code");
   a_excb_vector: assert property (
      pend_r && o_excb |-> pkt.addr == vec_r)
      else $error("exception branch address not vector");
   a_call_wpu_addr: assert property (
      pend_r && idx_r inside {3'h1, 3'h2, 3'h3} && o_wpu |-> pkt.addr == fa_r)
      else $error("update address not faulting call");
   a_fail_quiet: assert property (
      ex_take && call_k && !exc.cond_pass && !cmt.valid && !pkt_valid
      |=> !pkt_valid)
      else $error("packet for failed condition");
   a_isync_target: assert property (
      $rose(trace_en) && $past(in_ready) && !pkt_valid |-> ##2 pkt_valid &&
      pkt.kind == ets_pkg::ETS_PK_ISYNC && pkt.addr == tgt_r)
      else $error("sync missing or wrong address");
endmodule : ets_sequencer_properties

bind ets_sequencer ets_sequencer_properties u_props (.clk(clk), .rst(rst),
   .trace_en(trace_en), .cmt(cmt), .exc(exc), .in_ready(in_ready),
   .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt));

// *** tb/ets_core_model.sv ***
`timescale 1ns/1ps
module ets_core_model (
   input  wire logic            clk,      // Clock
   input  wire logic            rst,      // Reset
   input  wire logic            go,       // Present staged report
   input  ets_pkg::ets_commit_s c_in,     // Staged commit
   input  ets_pkg::ets_exc_s    e_in,     // Staged exception
   input  wire logic            in_ready, // Sequencer accepts
   output ets_pkg::ets_commit_s cmt,      // Commit report
   output ets_pkg::ets_exc_s    exc,      // Exception report
   output wire logic            busy      // Report not yet taken
);
   assign busy = cmt.valid || exc.valid;
   // Hold a report until taken, then scramble the idle fields
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmt <= '0;
         exc <= '0;
      end else if (go) begin
         cmt <= c_in;
         exc <= e_in;
      end else if (busy && in_ready) begin
         cmt <= {1'b0, ~cmt[$bits(cmt)-2:0]};
         exc <= {1'b0, ~exc[$bits(exc)-2:0]};
      end
   end
endmodule : ets_core_model

// *** tb/ets_sequencer_bench.sv ***
`timescale 1ns/1ps
`include "ets_defs.svh"
module ets_sequencer_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic trace_en = 1'b0;
   logic pkt_ready = 1'b1;
   logic go = 1'b0;
   logic in_ready, pkt_valid, busy;
   ets_pkg::ets_commit_s c_in = '0;
   ets_pkg::ets_commit_s cmt;
   ets_pkg::ets_exc_s e_in = '0;
   ets_pkg::ets_exc_s exc;
   ets_pkg::ets_pkt_s pkt;
   ets_pkg::ets_pkt_s q[$];
   int n_mismatch = 0;
   int tests_run = 0;
   localparam ets_pkg::ets_commit_s NOC = '0;
   localparam ets_pkg::ets_exc_s NOE = '0;
   localparam ets_pkg::ets_exc_kind_e CK [3] = '{ets_pkg::ETS_EK_UNDEF,
      ets_pkg::ETS_EK_SUPV, ets_pkg::ETS_EK_SMON};
   localparam logic [3:0] CC [3] = '{`ETS_EXC_UNDEF, `ETS_EXC_SVC,
      `ETS_EXC_SMC};
   localparam ets_pkg::ets_exc_kind_e AK [4] = '{ets_pkg::ETS_EK_PABT,
      ets_pkg::ETS_EK_DABT, ets_pkg::ETS_EK_FAST, ets_pkg::ETS_EK_NONMASKABLE_FAST_INTERRUPT};
   localparam logic [3:0] AC [4] = '{`ETS_EXC_PABT, `ETS_EXC_DABT,
      `ETS_EXC_FAST, `ETS_EXC_FAST};
   always #50 clk = ~clk;
   ets_core_model core (.clk(clk), .rst(rst), .go(go), .c_in(c_in),
      .e_in(e_in), .in_ready(in_ready), .cmt(cmt), .exc(exc), .busy(busy));
   ets_sequencer uut (.clk(clk), .rst(rst), .trace_en(trace_en), .cmt(cmt),
      .exc(exc), .in_ready(in_ready), .pkt_valid(pkt_valid),
      .pkt_ready(pkt_ready), .pkt(pkt));
   // Collect every packet the sink takes
   always @(posedge clk) if (pkt_valid && pkt_ready) q.push_back(pkt);
   function automatic ets_pkg::ets_commit_s cm(logic [31:0] a, logic w,
                                               logic i, logic tk,
                                               logic [31:0] t);
      return '{1'b1, a, w, i, tk, t};
   endfunction : cm
   function automatic ets_pkg::ets_exc_s ex(ets_pkg::ets_exc_kind_e k,
                                            logic p, logic [31:0] f,
                                            logic [31:0] v);
      return '{1'b1, k, p, f, v};
   endfunction : ex
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic present(ets_pkg::ets_commit_s c, ets_pkg::ets_exc_s e);
      @(posedge clk);
      c_in <= c;
      e_in <= e;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask : present
   task automatic settle;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((busy || !in_ready || pkt_valid) && n < 40);
      chk("settle", n < 40, 1);
   endtask : settle
   task automatic send(ets_pkg::ets_commit_s c, ets_pkg::ets_exc_s e);
      present(c, e);
      settle();
   endtask : send
   task automatic want(ets_pkg::ets_pkt_kind_e k, logic [31:0] a,
                       logic [3:0] code);
      ets_pkg::ets_pkt_s p;
      p = '1;
      if (q.size() != 0) p = q.pop_front();
      chk("kind", p.kind, k);
      if (k == ets_pkg::ETS_PK_EXCB)
         chk("code", p.exc_code, code);
      if (k == ets_pkg::ETS_PK_ATOM)
         chk("atoms", {p.atom_cnt, p.atom_bits}, a);
      else
         chk("addr", p.addr, a);
   endtask : want
   task automatic t_enable;
      send(cm(32'h100, 1'b1, 1'b1, 1'b1, 32'h1000), NOE);
      @(posedge clk);
      trace_en <= 1'b1;
      settle();
      want(ets_pkg::ETS_PK_ISYNC, 32'h1000, 4'h0);
      chk("left", q.size(), 0);
   endtask : t_enable
   task automatic t_undef;
      send(cm(32'h2000, 1'b1, 1'b0, 1'b1, 32'h2004), NOE);
      send(cm(32'h2004, 1'b1, 1'b0, 1'b0, 32'h2008), NOE);
      @(posedge clk);
      pkt_ready <= 1'b0;
      present(NOC, ex(ets_pkg::ETS_EK_UNDEF, 1'b1, 32'h2008, 32'h4));
      repeat (4) @(posedge clk);
      pkt_ready <= 1'b1;
      settle();
      want(ets_pkg::ETS_PK_ATOM, {3'h2, 5'h01}, 4'h0);
      want(ets_pkg::ETS_PK_WPU, 32'h2008, 4'h0);
      want(ets_pkg::ETS_PK_EXCB, 32'h4, `ETS_EXC_UNDEF);
   endtask : t_undef
   task automatic t_calls;
      for (int i = 0; i < 3; i++) begin
         send(NOC, ex(CK[i], 1'b0, 32'h3000, 32'h8));
         chk("left", q.size(), 0);
         send(NOC, ex(CK[i], 1'b1, 32'h3100, 32'h8));
         want(ets_pkg::ETS_PK_WPU, 32'h3100, 4'h0);
         want(ets_pkg::ETS_PK_EXCB, 32'h8, CC[i]);
      end
   endtask : t_calls
   task automatic t_reset;
      send(cm(32'h5000, 1'b0, 1'b0, 1'b0, 32'h5004), NOE);
      send(NOC, ex(ets_pkg::ETS_EK_RESET, 1'b1, 32'h5004, 32'h40));
      want(ets_pkg::ETS_PK_EXCB, 32'h40, `ETS_EXC_RESET);
      chk("left", q.size(), 0);
   endtask : t_reset
   task automatic t_aborts;
      for (int i = 0; i < 4; i++) begin
         send(cm(32'h6000, 1'b1, 1'b1, 1'b1, 32'h7000),
              ex(AK[i], 1'b1, 32'h0, 32'hC));
         want(ets_pkg::ETS_PK_BRA, 32'h7000, 4'h0);
         want(ets_pkg::ETS_PK_EXCB, 32'hC, AC[i]);
         send(cm(32'hC, 1'b0, 1'b0, 1'b0, 32'h10), NOE);
         send(NOC, ex(AK[i], 1'b1, 32'h0, 32'h14));
         want(ets_pkg::ETS_PK_WPU, 32'hC, 4'h0);
         want(ets_pkg::ETS_PK_EXCB, 32'h14, AC[i]);
      end
   endtask : t_aborts
   // Cut a hang short
   initial begin
      #500000;
      n_mismatch++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_enable();
      t_undef();
      t_calls();
      t_reset();
      t_aborts();
      tally_and_finish();
   end
endmodule : ets_sequencer_bench
